// File: settings_pkg.sv
// Shared constants, types and helpers for the power, LDO and address bank
package settings_pkg;
  // -------------------------------------------------------------
  // Register map and widths
  // -------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_POWER = 3'h0;
  localparam logic [2:0] OFS_LDO = 3'h1;
  localparam logic [2:0] OFS_ADDR = 3'h2;
  localparam logic [2:0] OFS_STATUS = 3'h3;
  // -------------------------------------------------------------
  // Reset values and writable masks
  // -------------------------------------------------------------
  localparam logic [7:0] RST_POWER = 8'h01;
  localparam logic [7:0] RST_LDO = 8'h08;
  localparam logic [7:0] RST_ADDR = 8'h08;
  localparam logic [7:0] LDO_WMASK = 8'h0f;
  localparam logic [7:0] ADDR_WMASK = 8'h7f;
  localparam logic [6:0] ADDR_ZERO_SUB = 7'h08;
  // -------------------------------------------------------------
  // Counts
  // -------------------------------------------------------------
  localparam int SLOT_CYCLES = 16;
  localparam int NUM_CELLS = 5;
  // -------------------------------------------------------------
  // Types
  // -------------------------------------------------------------
  typedef enum logic [0:0] {PACE_RUN = 1'b0, PACE_FILL = 1'b1} pace_state_t;
  typedef struct packed {
    logic [1:0] normal_pace;
    logic [1:0] balancing_scan_pace;
    logic die_hot_shutdown_select;
    logic slow_osc_watchdog_shutdown_select;
    logic deep_sleep_osc_keep;
    logic sleep_allow_default;
  } power_cfg_t;
  typedef struct packed {
    logic [3:0] rsvd;
    logic enable_default;
    logic [2:0] ldo_level_field;
  } ldo_cfg_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic valid;
    logic enable;
    logic [2:0] level;
  } ldo_cmd_t;
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Filler slots after each loop: full, half, quarter, eighth speed
  function automatic logic [2:0] pace_fillers(input logic [1:0] code);
    case (code)
      2'h0: pace_fillers = 3'h0;
      2'h1: pace_fillers = 3'h1;
      2'h2: pace_fillers = 3'h3;
      default: pace_fillers = 3'h7;
    endcase
  endfunction
  // LDO level code to output voltage in millivolts
  function automatic logic [15:0] ldo_mv(input logic [2:0] lvl);
    case (lvl)
      3'h4: ldo_mv = 16'h09c4;
      3'h5: ldo_mv = 16'h0bb8;
      3'h6: ldo_mv = 16'h0ce4;
      3'h7: ldo_mv = 16'h1388;
      default: ldo_mv = 16'h0708;
    endcase
  endfunction
  // Stored zero maps to the substitute target address
  function automatic logic [6:0] eff_addr(input logic [6:0] f);
    eff_addr = (f == 7'h00) ? ADDR_ZERO_SUB : f;
  endfunction
endpackage

// File: scan_pacer.sv
// Scan loop pacer that inserts filler slots after each scan loop
`timescale 1ns/1ns
module scan_pacer
  import settings_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst_sync_n, // Synchronised reset, active low
  input wire logic slot_tick, // One-cycle slot enable
  input wire logic loop_done, // Voltage and temperature loop ended
  input wire logic balancing_active, // Cell balancing running
  input wire logic [1:0] normal_pace, // Pace while not balancing
  input wire logic [1:0] balancing_scan_pace, // Pace while balancing
  output logic scan_go, // Next scan loop may start
  output logic current_only_slot, // Current-only slot pulse
  output logic idle_slot // Idle slot pulse
);
  import settings_pkg::*;

  pace_state_t state; // Pacer state
  logic [2:0] fill_left; // Filler slots still owed
  logic fill_bal; // Fillers belong to balancing mode
  wire logic [1:0] sel_pace; // Pace field in force
  wire logic [2:0] fillers; // Fillers for this loop

  // -------------------------------------------------------------
  // Pace selection
  // -------------------------------------------------------------
  assign sel_pace = balancing_active ? balancing_scan_pace
                                     : normal_pace;
  assign fillers = pace_fillers(sel_pace);
  assign scan_go = (state == PACE_RUN);

  // Load fillers at loop end, spend one per slot tick
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= PACE_RUN;
      fill_left <= 3'h0;
      fill_bal <= 1'b0;
      current_only_slot <= 1'b0;
      idle_slot <= 1'b0;
    end else begin
      current_only_slot <= 1'b0;
      idle_slot <= 1'b0;
      case (state)
        PACE_RUN: begin
          if (loop_done && fillers != 3'h0) begin
            fill_left <= fillers;
            fill_bal <= balancing_active;
            state <= PACE_FILL;
          end
        end
        PACE_FILL: begin
          if (slot_tick) begin
            current_only_slot <= !fill_bal;
            idle_slot <= fill_bal;
            fill_left <= fill_left - 3'h1;
            if (fill_left == 3'h1) begin
              state <= PACE_RUN;
            end
          end
        end
        default: state <= PACE_RUN;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);
  property p_normal_pace;
    scan_go && loop_done && !balancing_active
      |=> (fill_left == pace_fillers($past(normal_pace)))
          || ($past(normal_pace) == 2'h0 && scan_go);
  endproperty
  a_normal_pace: assert property (p_normal_pace)
    else $error("normal pace fill count wrong");
  property p_balance_pace;
    scan_go && loop_done && balancing_active
      |=> (fill_left == pace_fillers($past(balancing_scan_pace)))
          || ($past(balancing_scan_pace) == 2'h0 && scan_go);
  endproperty
  a_balance_pace: assert property (p_balance_pace)
    else $error("balancing pace fill count wrong");
  property p_slot_kind;
    idle_slot |-> !current_only_slot && $past(fill_bal);
  endproperty
  a_slot_kind: assert property (p_slot_kind)
    else $error("idle slot outside balancing pacing");
  c_eighth: cover property (scan_go && loop_done && fillers == 3'h7);
endmodule

// File: power_ldo_address_settings.sv
// Power, LDO and target address settings bank with its selected behaviour
`timescale 1ns/1ns
module power_ldo_address_settings
  import settings_pkg::*;
#(
  parameter int CELLS = NUM_CELLS, // Number of balanced cells
  parameter int SLOT_DIV = SLOT_CYCLES // Clock cycles per scan slot
)
(
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input settings_pkg::reg_req_t bus_req, // Register access request
  output logic [7:0] rdata, // Read data, cycle after read
  input wire logic config_edit_mode, // Settings-edit mode level
  input wire logic sleep_allow_cmd, // Sleep-allow subcommand pulse
  input wire logic sleep_forbid_cmd, // Sleep-forbid subcommand pulse
  input settings_pkg::ldo_cmd_t ldo_cmd, // LDO control command
  input wire logic die_hot_fault, // Die over-temperature fault
  input wire logic slow_osc_wd_fault, // Slow oscillator watchdog fault
  input wire logic deepest_low_power_mode, // Deepest low-power mode
  input wire logic balancing_active, // Cell balancing running
  input wire logic [CELLS-1:0] balance_request, // Cells to balance
  input wire logic [CELLS-1:0] measuring_cell, // Cells being measured
  input wire logic loop_done, // Scan loop finished pulse
  output logic scan_go, // Next scan loop may start
  output logic current_only_slot, // Current-only slot pulse
  output logic idle_slot, // Idle slot pulse
  output logic [CELLS-1:0] cell_balance_on, // Balance switches
  output logic shutdown_req, // Shutdown request, sticky
  output logic slow_osc_run, // Slow oscillator enable
  output logic sleep_allow_flag, // Sleep-allow status flag
  output logic aux_ldo_enable, // Auxiliary LDO enable
  output logic [2:0] ldo_level, // Auxiliary LDO level code
  output logic [15:0] ldo_millivolts, // Auxiliary LDO voltage in mV
  output logic [6:0] target_address // Serial bus target address
);
  import settings_pkg::*;

  // -------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------
  logic rst_meta_n; // First synchroniser stage
  logic rst_sync_n; // Synchronised reset used by the design

  // Release the reset through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // -------------------------------------------------------------
  // Settings registers
  // -------------------------------------------------------------
  power_cfg_t pwr; // Power mode settings byte
  ldo_cfg_t ldo; // LDO output settings byte
  logic [7:0] addr_reg; // Target address byte
  wire logic wr_pwr; // Write to power settings
  wire logic wr_ldo; // Write to LDO settings
  wire logic wr_addr; // Write to address settings
  wire logic rd_hit; // Read of a mapped offset
  wire logic [7:0] status_byte; // Live state view
  wire logic [7:0] rd_mux; // Selected read value

  // Address decode
  assign wr_pwr = bus_req.wr && (bus_req.addr == OFS_POWER);
  assign wr_ldo = bus_req.wr && (bus_req.addr == OFS_LDO);
  assign wr_addr = bus_req.wr && (bus_req.addr == OFS_ADDR);
  assign rd_hit = (bus_req.addr <= OFS_STATUS);

  // Status view of the live state
  assign status_byte = {config_edit_mode, shutdown_req, slow_osc_run,
                        sleep_allow_flag, aux_ldo_enable, ldo_level};

  // Read selection; unmapped offsets read zero
  assign rd_mux = (bus_req.addr == OFS_POWER) ? pwr :
                  (bus_req.addr == OFS_LDO) ? ldo :
                  (bus_req.addr == OFS_ADDR) ? addr_reg :
                  rd_hit ? status_byte : 8'h00;

  // Settings storage; reserved bits stay zero
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwr <= RST_POWER;
      ldo <= RST_LDO;
      addr_reg <= RST_ADDR;
    end else begin
      if (wr_pwr) begin
        pwr <= bus_req.wdata;
      end
      if (wr_ldo) begin
        ldo <= bus_req.wdata & LDO_WMASK;
      end
      if (wr_addr) begin
        addr_reg <= bus_req.wdata & ADDR_WMASK;
      end
    end
  end

  // Read data stands for the one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // -------------------------------------------------------------
  // Sleep-allow flag
  // -------------------------------------------------------------
  logic init_pending; // High in the first cycle after release
  logic next_sleep; // Next sleep-allow flag value

  // Default copy at initialization, subcommands afterwards
  always_comb begin
    next_sleep = sleep_allow_flag;
    if (init_pending) begin
      next_sleep = pwr.sleep_allow_default;
    end else if (sleep_allow_cmd) begin
      next_sleep = 1'b1;
    end else if (sleep_forbid_cmd) begin
      next_sleep = 1'b0;
    end
  end

  // Flag and initialization marker
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      init_pending <= 1'b1;
      sleep_allow_flag <= 1'b0;
    end else begin
      init_pending <= 1'b0;
      sleep_allow_flag <= next_sleep;
    end
  end

  // -------------------------------------------------------------
  // Auxiliary LDO
  // -------------------------------------------------------------
  logic edit_q; // Edit mode seen last cycle
  wire logic edit_exit; // Falling edge of edit mode
  logic next_ldo_en; // Next LDO enable
  logic [2:0] next_ldo_lvl; // Next LDO level

  assign edit_exit = edit_q && !config_edit_mode;

  // A command in the exit cycle wins, being the newer intent
  always_comb begin
    next_ldo_en = aux_ldo_enable;
    next_ldo_lvl = ldo_level;
    if (ldo_cmd.valid) begin
      next_ldo_en = ldo_cmd.enable;
      next_ldo_lvl = ldo_cmd.level;
    end else if (edit_exit) begin
      next_ldo_en = ldo.enable_default;
      next_ldo_lvl = ldo.ldo_level_field;
    end
  end

  // Live LDO state and its voltage
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      edit_q <= 1'b0;
      aux_ldo_enable <= 1'b0;
      ldo_level <= 3'h0;
      ldo_millivolts <= 16'h0708;
    end else begin
      edit_q <= config_edit_mode;
      aux_ldo_enable <= next_ldo_en;
      ldo_level <= next_ldo_lvl;
      ldo_millivolts <= ldo_mv(next_ldo_lvl);
    end
  end

  // -------------------------------------------------------------
  // Shutdown, oscillator, address, balancing
  // -------------------------------------------------------------
  wire logic hot_trip; // Die fault selected for shutdown
  wire logic wd_trip; // Watchdog fault selected for shutdown

  assign hot_trip = die_hot_fault && pwr.die_hot_shutdown_select;
  assign wd_trip = slow_osc_wd_fault
                   && pwr.slow_osc_watchdog_shutdown_select;

  // Shutdown holds until reset; oscillator and address follow settings
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      shutdown_req <= 1'b0;
      slow_osc_run <= 1'b1;
      target_address <= ADDR_ZERO_SUB;
      cell_balance_on <= '0;
    end else begin
      shutdown_req <= shutdown_req || hot_trip || wd_trip;
      slow_osc_run <= !deepest_low_power_mode
                      || pwr.deep_sleep_osc_keep;
      target_address <= eff_addr(addr_reg[6:0]);
      cell_balance_on <= balance_request & ~measuring_cell;
    end
  end

  // -------------------------------------------------------------
  // Scan pacing
  // -------------------------------------------------------------
  localparam int DIV_W = $clog2(SLOT_DIV);
  logic [DIV_W-1:0] div_cnt; // Slot divider
  wire logic slot_tick; // One-cycle slot enable

  assign slot_tick = (div_cnt == DIV_W'(SLOT_DIV - 1));

  // Slot rate divider
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= slot_tick ? '0 : div_cnt + 1'b1;
    end
  end

  // Pacer for both scan modes
  scan_pacer u_pacer (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .slot_tick(slot_tick),
    .loop_done(loop_done),
    .balancing_active(balancing_active),
    .normal_pace(pwr.normal_pace),
    .balancing_scan_pace(pwr.balancing_scan_pace),
    .scan_go(scan_go),
    .current_only_slot(current_only_slot),
    .idle_slot(idle_slot)
  );

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  property p_sleep_init;
    init_pending |=> sleep_allow_flag == $past(pwr.sleep_allow_default);
  endproperty
  a_sleep_init: assert property (p_sleep_init)
    else $error("sleep flag not loaded from default");

  property p_sleep_cmd;
    !init_pending && (sleep_allow_cmd || sleep_forbid_cmd)
      |=> sleep_allow_flag == $past(sleep_allow_cmd);
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd)
    else $error("sleep subcommand not applied");

  property p_hot;
    die_hot_fault && pwr.die_hot_shutdown_select |=> shutdown_req [*2];
  endproperty
  a_hot: assert property (p_hot)
    else $error("die hot fault did not shut down");

  property p_no_trip;
    !shutdown_req && !hot_trip && !wd_trip |=> !shutdown_req;
  endproperty
  a_no_trip: assert property (p_no_trip)
    else $error("shutdown without selected fault");

  property p_wd;
    slow_osc_wd_fault && pwr.slow_osc_watchdog_shutdown_select
      |=> shutdown_req;
  endproperty
  a_wd: assert property (p_wd)
    else $error("watchdog fault did not shut down");

  property p_osc;
    deepest_low_power_mode && !pwr.deep_sleep_osc_keep |=> !slow_osc_run;
  endproperty
  a_osc: assert property (p_osc)
    else $error("slow oscillator left running");

  property p_ldo_exit;
    edit_exit && !ldo_cmd.valid
      |=> aux_ldo_enable == $past(ldo.enable_default)
          && ldo_level == $past(ldo.ldo_level_field);
  endproperty
  a_ldo_exit: assert property (p_ldo_exit)
    else $error("LDO not loaded on edit exit");

  property p_ldo_mv;
    ldo_millivolts == ldo_mv(ldo_level);
  endproperty
  a_ldo_mv: assert property (p_ldo_mv)
    else $error("LDO voltage does not match level");

  property p_addr;
    ##1 target_address == eff_addr($past(addr_reg[6:0]));
  endproperty
  a_addr: assert property (p_addr)
    else $error("target address wrong");

  property p_ldo_wr;
    wr_ldo |=> ldo == ($past(bus_req.wdata) & LDO_WMASK);
  endproperty
  a_ldo_wr: assert property (p_ldo_wr)
    else $error("LDO settings write wrong");

  property p_addr_wr;
    wr_addr |=> addr_reg == ($past(bus_req.wdata) & ADDR_WMASK);
  endproperty
  a_addr_wr: assert property (p_addr_wr)
    else $error("address settings write wrong");

  property p_rd_idle;
    !bus_req.rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the read cycle");

  property p_rd_pwr;
    bus_req.rd && bus_req.addr == OFS_POWER |=> rdata == $past(pwr);
  endproperty
  a_rd_pwr: assert property (p_rd_pwr)
    else $error("power settings read wrong");

  property p_bal;
    ##1 (cell_balance_on & $past(measuring_cell)) == '0;
  endproperty
  a_bal: assert property (p_bal)
    else $error("balancing during cell measurement");

  c_edit_exit: cover property (edit_exit && !ldo_cmd.valid);
  c_shutdown: cover property (!shutdown_req ##1 shutdown_req);
  c_addr_zero: cover property (addr_reg == 8'h00 ##1 target_address == 7'h08);
  c_idle: cover property (idle_slot);
endmodule

// File: power_ldo_address_settings_tb.sv
// Self-checking testbench for the power, LDO and address settings bank
`timescale 1ns/1ns
module power_ldo_address_settings_tb;
  import settings_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0; // System clock, 8 ns period
  logic rst_n = 1'b1; // Reset, active low; falls at time zero
  reg_req_t bus_req = '0; // Register request
  logic config_edit_mode = 1'b0; // Settings-edit mode level
  logic sleep_allow_cmd = 1'b0, sleep_forbid_cmd = 1'b0; // Subcommands
  ldo_cmd_t ldo_cmd = '0; // LDO control command
  logic die_hot_fault = 1'b0, slow_osc_wd_fault = 1'b0; // Faults
  logic deepest_low_power_mode = 1'b0, balancing_active = 1'b0;
  logic loop_done = 1'b0; // Scan loop finished
  logic [NUM_CELLS-1:0] balance_request = '0, measuring_cell = '0;
  logic [7:0] rdata;
  logic scan_go, current_only_slot, idle_slot, shutdown_req, slow_osc_run;
  logic sleep_allow_flag, aux_ldo_enable;
  logic [NUM_CELLS-1:0] cell_balance_on;
  logic [2:0] ldo_level;
  logic [15:0] ldo_millivolts;
  logic [6:0] target_address;
  int fail_count = 0, tests_run = 0; // Verdict counters
  logic [15:0] lfsr = 16'h4333; // Random source, seed 17203
  logic [15:0] d; // Current random word
  int m_pow, m_ldo, m_adr; // Model copies of the settings bytes

  // Free-running clock
  always #4 clk_sys = ~clk_sys;

  // Short slot length keeps the pacing scenarios brief
  power_ldo_address_settings #(.CELLS(NUM_CELLS), .SLOT_DIV(4)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .config_edit_mode(config_edit_mode), .sleep_allow_cmd(sleep_allow_cmd),
    .sleep_forbid_cmd(sleep_forbid_cmd), .ldo_cmd(ldo_cmd),
    .die_hot_fault(die_hot_fault), .slow_osc_wd_fault(slow_osc_wd_fault),
    .deepest_low_power_mode(deepest_low_power_mode),
    .balancing_active(balancing_active), .balance_request(balance_request),
    .measuring_cell(measuring_cell), .loop_done(loop_done),
    .scan_go(scan_go), .current_only_slot(current_only_slot),
    .idle_slot(idle_slot), .cell_balance_on(cell_balance_on),
    .shutdown_req(shutdown_req), .slow_osc_run(slow_osc_run),
    .sleep_allow_flag(sleep_allow_flag), .aux_ldo_enable(aux_ldo_enable),
    .ldo_level(ldo_level), .ldo_millivolts(ldo_millivolts),
    .target_address(target_address));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Step the shift register and return the new word
  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // Expected LDO voltage in millivolts for a level code
  function logic [15:0] exp_mv(input int l);
    case (l)
      4: return 16'd2500;
      5: return 16'd3000;
      6: return 16'd3300;
      7: return 16'd5000;
      default: return 16'd1800;
    endcase
  endfunction
  // Compare one result and count it
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Print the verdict and stop
  task give_verdict;
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Let n edges pass, then settle past the last one
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Reset for 16 cycles and restore the model
  task do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(4);
    m_pow = 8'h01;
    m_ldo = 8'h08;
    m_adr = 8'h08;
  endtask
  // One-cycle register write; the model keeps only writable bits
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    case (a)
      3'h0: m_pow = v;
      3'h1: m_ldo = v & 8'h0f;
      3'h2: m_adr = v & 8'h7f;
      default: ;
    endcase
  endtask
  // One-cycle register read, data checked in the following cycle
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  // One scan loop with given pace codes; count filler slots
  task pace_run(input int p, input logic b);
    int cur, idl, n;
    cur = 0;
    idl = 0;
    n = b ? (1 << (3 - p)) - 1 : (1 << p) - 1;
    wr(3'h0, {2'(p), 2'(3 - p), 4'h1});
    @(posedge clk_sys);
    balancing_active <= b;
    loop_done <= 1'b1;
    @(posedge clk_sys);
    loop_done <= 1'b0;
    repeat (48) begin
      @(posedge clk_sys);
      #1;
      cur += int'(current_only_slot);
      idl += int'(idle_slot);
    end
    chk("current_only_slot", b ? 16'd0 : 16'(n), 16'(cur));
    chk("idle_slot", b ? 16'(n) : 16'd0, 16'(idl));
    chk("scan_go", 16'd1, {15'd0, scan_go});
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset;
    chk("sleep_allow_flag", 16'd1, {15'd0, sleep_allow_flag});
    chk("target_address", 16'h08, {9'd0, target_address});
    rd(3'h0, 8'h01);
    rd(3'h1, 8'h08);
    rd(3'h2, 8'h08);
    // Random bytes, reserved bits and unmapped places
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      wr(3'h0, d[7:0]);
      wr(3'h1, d[15:8]);
      wr(3'h2, d[7:0] ^ d[15:8]);
      wr(3'h3, 8'hff);
      rd(3'h3, 8'h30);
      rd(3'h0, 8'(m_pow));
      rd(3'h1, 8'(m_ldo));
      rd(3'h2, 8'(m_adr));
      rd(3'h5, 8'h00);
      tick(2);
      chk("target_address", (m_adr == 0) ? 16'h08 : 16'(m_adr),
          {9'd0, target_address});
    end
    wr(3'h2, 8'h80);
    tick(3);
    chk("target_address", 16'h08, {9'd0, target_address});
    // Sleep subcommands: forbid, allow, forbid, both at once
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      sleep_forbid_cmd <= (i != 1);
      sleep_allow_cmd <= (i[0] == 1'b1);
      @(posedge clk_sys);
      sleep_forbid_cmd <= 1'b0;
      sleep_allow_cmd <= 1'b0;
      #1;
      chk("sleep_allow_flag", {15'd0, i[0]}, {15'd0, sleep_allow_flag});
    end
    // LDO defaults loaded on edit exit, then overridden by command
    for (int l = 0; l < 8; l++) begin
      wr(3'h1, {4'hf, l[0], l[2:0]});
      @(posedge clk_sys);
      config_edit_mode <= 1'b1;
      @(posedge clk_sys);
      config_edit_mode <= 1'b0;
      tick(3);
      chk("aux_ldo_enable", {15'd0, l[0]}, {15'd0, aux_ldo_enable});
      chk("ldo_level", 16'(l), {13'd0, ldo_level});
      chk("ldo_millivolts", exp_mv(l), ldo_millivolts);
      @(posedge clk_sys);
      ldo_cmd <= '{valid: 1'b1, enable: ~l[0], level: 3'(7 - l)};
      @(posedge clk_sys);
      ldo_cmd.valid <= 1'b0;
      tick(2);
      chk("aux_ldo_enable", {15'd0, ~l[0]}, {15'd0, aux_ldo_enable});
      chk("ldo_level", 16'(7 - l), {13'd0, ldo_level});
      chk("ldo_millivolts", exp_mv(7 - l), ldo_millivolts);
    end
    // Balancing paused on cells under measurement
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      @(posedge clk_sys);
      balance_request <= d[4:0];
      measuring_cell <= d[12:8];
      balancing_active <= d[15];
      tick(2);
      chk("cell_balance_on", {11'd0, d[4:0] & ~d[12:8]},
          {11'd0, cell_balance_on});
    end
    // Every pace code in both modes
    for (int p = 0; p < 4; p++) begin
      pace_run(p, 1'b0);
      pace_run(p, 1'b1);
    end
    // Slow oscillator in the deepest mode against the keep bit
    for (int i = 0; i < 4; i++) begin
      wr(3'h0, {6'h00, i[0], 1'b1});
      @(posedge clk_sys);
      deepest_low_power_mode <= i[1];
      tick(3);
      chk("slow_osc_run", {15'd0, ~i[1] | i[0]}, {15'd0, slow_osc_run});
    end
    deepest_low_power_mode <= 1'b0;
    // Faults with selects clear, then each select alone
    die_hot_fault <= 1'b1;
    slow_osc_wd_fault <= 1'b1;
    wr(3'h0, 8'h01);
    tick(4);
    chk("shutdown_req", 16'd0, {15'd0, shutdown_req});
    wr(3'h0, 8'h09);
    tick(3);
    chk("shutdown_req", 16'd1, {15'd0, shutdown_req});
    die_hot_fault <= 1'b0;
    do_reset;
    wr(3'h0, 8'h05);
    tick(3);
    chk("shutdown_req", 16'd1, {15'd0, shutdown_req});
    slow_osc_wd_fault <= 1'b0;
    do_reset;
    give_verdict;
  end

  // Guard against a hang
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    give_verdict;
  end
endmodule
